// ---- shared/sahi_pkg.sv ----
// shared constants and types of the converter host interface
package sahi_pkg;

    // ==========================================================
    // result format
    localparam int RES_BITS = 12;                  // result width, bit 11 is msb
    localparam int BYTE_BITS = 8;                  // width of the data pin group
    localparam int HIGH_BITS = 4;                  // upper result bits on a high byte read
    localparam logic [11:0] RESULT_RESET = 12'h000; // output latch after reset
    localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800; // msb trial at conversion start
    localparam logic [11:0] MSB_INVERT = 12'h800;  // msb flip for signed range

    // ==========================================================
    // pin positions on the data group in serial mode
    localparam int PIN_SDATA = 7;                  // serial data
    localparam int PIN_SCLK = 6;                   // serial clock out
    localparam int PIN_STROBE = 5;                 // frame strobe
    localparam int LOW_PINS = 5;                   // pins held low in serial mode

    // ==========================================================
    // synchroniser bit positions
    localparam int SYNC_W = 8;
    localparam int S_CS_N = 0;
    localparam int S_RD_N = 1;
    localparam int S_UBS = 2;                      // upper byte select
    localparam int S_IFS = 3;                      // interface select
    localparam int S_SRS = 4;                      // signed range select
    localparam int S_CCLK = 5;                     // conversion clock pin
    localparam int S_CMP = 6;                      // comparator decision
    localparam int S_EXT = 7;                      // external clock select
    localparam logic [7:0] SYNC_RESET = 8'h3b;     // strobes idle high

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int HOLD_DELAY_NS = 25;             // start to hold
    localparam int HOLD_DELAY_CYC = (HOLD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] HOLD_CNT_INIT = 2'(HOLD_DELAY_CYC);
    localparam int OSC_PERIOD_NS = 1000;           // internal oscillator, 1 mhz nominal
    localparam int OSC_HALF_CYC = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [5:0] OSC_HALF_LAST = 6'(OSC_HALF_CYC - 1);
    localparam int EXT_CLK_MIN_KHZ = 100;          // allowed external clock range
    localparam int EXT_CLK_MAX_KHZ = 1600;
    localparam int START_GUARD_BEFORE_NS = 50;     // quiet time around clock edges
    localparam int START_GUARD_AFTER_NS = 100;
    localparam logic [3:0] DONE_EDGE = 4'hd;       // 13th falling edge ends conversion
    localparam logic [3:0] LAST_DECISION = 4'hc;   // edge that decides bit 0

    // ==========================================================
    // sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_CONV, ST_PUSH} sahi_state_t;

endpackage

// ---- hdl/sahi_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sahi_sync
    import sahi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [sahi_pkg::SYNC_W-1:0] pin_in,
    output logic [sahi_pkg::SYNC_W-1:0] pin_sync
);
    import sahi_pkg::*;
    // ==========================================================
    // state
    typedef struct packed {
        logic [SYNC_W-1:0] meta;   // first stage, read only by the second
        logic [SYNC_W-1:0] safe;   // second stage
    } sahi_sync_t;

    sahi_sync_t st;
    sahi_sync_t next_st;

    // shift each bit through both stages
    always_comb begin
        next_st.meta = pin_in;
        next_st.safe = st.meta;
    end

    // registers with idle reset levels
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st <= '{meta: SYNC_RESET, safe: SYNC_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign pin_sync = st.safe;
endmodule // sahi_sync
`default_nettype wire

// ---- hdl/sahi_buf.sv ----
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sahi_buf
    import sahi_pkg::*;
#(
    parameter int WIDTH = sahi_pkg::RES_BITS
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import sahi_pkg::*;
    // ==========================================================
    // state
    typedef struct packed {
        logic [1:0][WIDTH-1:0] entry; // storage
        logic wr_ptr;                 // next slot to fill
        logic rd_ptr;                 // oldest slot
        logic [1:0] count;            // words held, 0 to 2
    } sahi_buf_t;

    sahi_buf_t st;
    sahi_buf_t next_st;
    logic push;
    logic pop;

    // honest flags from the word count
    assign in_ready = (st.count != 2'h2);
    assign out_valid = (st.count != 2'h0);
    assign out_data = st.entry[st.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.entry[st.wr_ptr] = in_data;
            next_st.wr_ptr = ~st.wr_ptr;
        end
        if (pop) begin
            next_st.rd_ptr = ~st.rd_ptr;
        end
        if (push && !pop) begin
            next_st.count = st.count + 2'h1;
        end else if (pop && !push) begin
            next_st.count = st.count - 2'h1;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // sahi_buf
`default_nettype wire

// ---- hdl/sahi_core.sv ----
// conversion sequencer, result latch and pin interface of the converter
`timescale 1ns/1ps
`default_nettype none
module sahi_core
    import sahi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic upper_byte_select,
    input wire logic interface_select,
    input wire logic signed_range_select,
    input wire logic ext_clock_select,
    input wire logic conv_clk_in,
    input wire logic comparator_high,
    output logic busy_n,
    output logic hold_active,
    output logic [sahi_pkg::RES_BITS-1:0] dac_code,
    output logic [sahi_pkg::BYTE_BITS-1:0] data_out,
    output logic [sahi_pkg::BYTE_BITS-1:0] data_oe
);
    import sahi_pkg::*;

    // ==========================================================
    // state of the whole block
    typedef struct packed {
        sahi_state_t state;                // sequencer state
        logic [3:0] edge_cnt;              // falling edges since start
        logic [RES_BITS-1:0] sar;          // approximation register
        logic [1:0] hold_cnt;              // delay to hold
        logic hold;                        // sample stage in hold
        logic busy_n;                      // busy, active low
        logic [RES_BITS-1:0] latch;        // visible output latch
        logic clk_prev;                    // conversion clock last cycle
        logic start_prev;                  // start combination last cycle
        logic cs_prev;                     // select last cycle
        logic sdata;                       // serial data bit
        logic strobe;                      // frame strobe
        logic ser_begun;                   // serial conversion has begun
        logic [5:0] osc_cnt;               // internal oscillator divider
        logic osc_level;                   // internal oscillator output
        logic [BYTE_BITS-1:0] pins_out;    // data pin levels
        logic [BYTE_BITS-1:0] pins_oe;     // data pin enables
    } sahi_core_t;

    sahi_core_t st;
    sahi_core_t next_st;

    // ==========================================================
    // pin synchronisers
    logic [SYNC_W-1:0] pin_raw;   // raw pin group
    logic [SYNC_W-1:0] pin_s;     // synchronised pin group
    // bit order follows the synchroniser positions of the package

    assign pin_raw = {ext_clock_select, comparator_high, conv_clk_in,
                      signed_range_select, interface_select, upper_byte_select,
                      rd_n, cs_n};

    sahi_sync u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_in(pin_raw),
        .pin_sync(pin_s)
    );

    // ==========================================================
    // result buffer between sequencer and output latch
    logic buf_in_valid;               // finished result offered
    logic buf_in_ready;               // buffer has room
    logic [RES_BITS-1:0] buf_in_data; // formatted result
    logic buf_out_valid;              // result waiting for the latch
    logic buf_out_ready;              // latch may take it
    logic [RES_BITS-1:0] buf_out_data;

    sahi_buf #(.WIDTH(RES_BITS)) u_buf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // ==========================================================
    // decoded pin conditions
    logic cs_low;        // chip selected
    logic rd_low;        // read strobe active
    logic ubs;           // upper byte select
    logic par_mode;      // parallel interface
    logic conv_level;    // chosen conversion clock
    logic conv_fall;     // falling edge of conversion clock
    logic start_combo;   // select, read and byte select all low
    logic par_start;     // parallel start event
    logic ser_start;     // serial start event
    logic [3:0] cnt_next; // edge count after this edge
    logic [3:0] bit_idx;  // bit being decided
    logic push_now;       // result offered this cycle

    assign cs_low = !pin_s[S_CS_N];
    assign rd_low = !pin_s[S_RD_N];
    assign ubs = pin_s[S_UBS];
    assign par_mode = pin_s[S_IFS];
    // external pin clock when selected, held in range by the outside party; otherwise the internal oscillator
    assign conv_level = pin_s[S_EXT] ? pin_s[S_CCLK] : st.osc_level;
    assign conv_fall = st.clk_prev && !conv_level;
    assign start_combo = cs_low && rd_low && !ubs;
    assign par_start = par_mode && start_combo && !st.start_prev;
    assign ser_start = !par_mode && cs_low && !st.cs_prev;
    assign cnt_next = st.edge_cnt + 4'h1;
    assign bit_idx = LAST_DECISION - cnt_next;
    // the result is offered on the done edge and while it waits for room
    assign push_now = (st.state == ST_PUSH)
                      || (st.state == ST_CONV && conv_fall && cnt_next == DONE_EDGE);

    // signed range flips only the msb; bit 11 stays the msb
    assign buf_in_data = pin_s[S_SRS] ? (st.sar ^ MSB_INVERT) : st.sar;
    assign buf_in_valid = push_now;
    // hold the latch still while an upper byte read is on the bus
    assign buf_out_ready = !(par_mode && cs_low && rd_low && ubs);

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.clk_prev = conv_level;
        next_st.start_prev = start_combo;
        next_st.cs_prev = cs_low;

        // internal oscillator from the system clock
        if (st.osc_cnt == OSC_HALF_LAST) begin
            next_st.osc_cnt = 6'h00;
            next_st.osc_level = !st.osc_level;
        end else begin
            next_st.osc_cnt = st.osc_cnt + 6'h01;
        end

        // delayed entry into hold after a start
        if (st.hold_cnt != 2'h0) begin
            next_st.hold_cnt = st.hold_cnt - 2'h1;
            if (st.hold_cnt == 2'h1) begin
                next_st.hold = 1'b1;
            end
        end

        // a cut frame still converts to the end; only the data enable drops
        // serial frame ends with the select
        if (!cs_low) begin
            next_st.ser_begun = 1'b0;
        end

        case (st.state)
            // waiting for a start, further starts impossible elsewhere
            ST_IDLE: begin
                if (!cs_low && st.hold_cnt == 2'h0) begin
                    next_st.hold = 1'b0;
                end
                if (par_start) begin
                    next_st.busy_n = 1'b0;
                    next_st.hold_cnt = HOLD_CNT_INIT;
                    next_st.edge_cnt = 4'h0;
                    next_st.sar = SAR_FIRST_TRIAL;
                    next_st.state = ST_CONV;
                end else if (ser_start) begin
                    next_st.busy_n = 1'b0;
                    next_st.hold_cnt = HOLD_CNT_INIT;
                    next_st.sar = SAR_FIRST_TRIAL;
                    next_st.state = ST_ARM;
                end
            end
            // serial: conversion begins on the next falling clock edge
            ST_ARM: begin
                if (conv_fall) begin
                    next_st.edge_cnt = 4'h0;
                    next_st.ser_begun = 1'b1;
                    next_st.sdata = 1'b0;
                    next_st.strobe = 1'b1;
                    next_st.state = ST_CONV;
                end
            end
            // one bit decision per falling edge, msb first
            ST_CONV: begin
                if (conv_fall) begin
                    next_st.edge_cnt = cnt_next;
                    next_st.strobe = 1'b0;
                    if (cnt_next <= LAST_DECISION) begin
                        if (!pin_s[S_CMP]) begin
                            next_st.sar[bit_idx] = 1'b0;
                        end
                        if (bit_idx != 4'h0) begin
                            next_st.sar[bit_idx - 4'h1] = 1'b1;
                        end
                        // decided bit goes out at once
                        next_st.sdata = pin_s[S_CMP];
                    end else begin
                        // trailing zeros after the last bit
                        next_st.sdata = 1'b0;
                        // a full buffer keeps busy low until the latch drains it
                        if (buf_in_ready) begin
                            next_st.busy_n = 1'b1;
                            next_st.state = ST_IDLE;
                        end else begin
                            next_st.state = ST_PUSH;
                        end
                    end
                end
            end
            // result waits for room in the buffer
            ST_PUSH: begin
                if (buf_in_ready) begin
                    next_st.busy_n = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase

        // latch takes the new result only once it is complete
        if (buf_out_valid && buf_out_ready) begin
            next_st.latch = buf_out_data;
        end

        // data pin group
        next_st.pins_out = '0;
        next_st.pins_oe = '0;
        if (par_mode) begin
            if (cs_low && rd_low) begin
                next_st.pins_oe = 8'hff;
                if (ubs) begin
                    next_st.pins_out = {{HIGH_BITS{1'b0}}, st.latch[11:8]};
                end else begin
                    next_st.pins_out = st.latch[7:0];
                end
            end
        end else if (cs_low) begin
            next_st.pins_out[PIN_SDATA] = st.sdata;
            next_st.pins_out[PIN_SCLK] = conv_level && (ubs || st.state == ST_CONV);
            next_st.pins_out[PIN_STROBE] = st.strobe;
            next_st.pins_oe[PIN_SDATA] = st.ser_begun;
            next_st.pins_oe[PIN_SCLK] = rd_low;
            next_st.pins_oe[PIN_STROBE] = rd_low;
            next_st.pins_oe[LOW_PINS-1:0] = {LOW_PINS{1'b1}};
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.busy_n <= 1'b1;
            st.latch <= RESULT_RESET;
            st.sar <= SAR_FIRST_TRIAL;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign busy_n = st.busy_n;
    assign hold_active = st.hold;
    assign dac_code = st.sar;
    assign data_out = st.pins_out;
    assign data_oe = st.pins_oe;
endmodule // sahi_core
`default_nettype wire

// ---- dv/sahi_chk.sv ----
// concurrent checks on the pins of the converter core
`timescale 1ns/1ps
`default_nettype none
module sahi_chk
    import sahi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic upper_byte_select,
    input wire logic interface_select,
    input wire logic busy_n,
    input wire logic hold_active,
    input wire logic [sahi_pkg::BYTE_BITS-1:0] data_out,
    input wire logic [sahi_pkg::BYTE_BITS-1:0] data_oe
);
    import sahi_pkg::*;
    // ==========================================================
    // helper counters
    localparam int MIN_CONV = 750;   // 12 periods of the fastest usable clock
    localparam int MAX_CONV = 16000; // 14 periods of the slowest clock plus margin
    logic [5:0] cond;     // pin conditions whose run length is counted
    logic [2:0] run [6];  // saturating run lengths of cond
    logic [14:0] lo_cnt;  // cycles busy has been low
    assign cond = {rd_n, !interface_select && !cs_n, !upper_byte_select,
        upper_byte_select, interface_select && !cs_n && !rd_n, cs_n};
    // count consecutive cycles of each condition, saturating at seven
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run <= '{default: 3'h0};
            lo_cnt <= 15'h0000;
        end else begin
            for (int i = 0; i < 6; i++) begin
                run[i] <= !cond[i] ? 3'h0 : (run[i] == 3'h7 ? run[i] : run[i] + 3'h1);
            end
            lo_cnt <= busy_n ? 15'h0000 : lo_cnt + 15'h0001;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // named steps of a conversion
    sequence s_par_start;
        busy_n && interface_select && $fell(cs_n || rd_n || upper_byte_select);
    endsequence
    sequence s_ser_start;
        busy_n && !interface_select && $fell(cs_n);
    endsequence
    sequence s_busy_low;
        !busy_n ##1 !busy_n;
    endsequence
    // ==========================================================
    // assertions
    chk_par_start: assert property (s_par_start |-> ##[1:6] s_busy_low)
        else $error("busy did not follow a parallel start");
    chk_ser_start: assert property (s_ser_start |-> ##[1:6] s_busy_low)
        else $error("busy did not follow a serial start");
    chk_hold_enter: assert property ($fell(busy_n) |-> ##[1:6] hold_active)
        else $error("hold not entered after start");
    chk_conv_min: assert property ($rose(busy_n) |-> lo_cnt >= MIN_CONV)
        else $error("conversion ended too early");
    chk_conv_max: assert property (!busy_n |-> lo_cnt < MAX_CONV)
        else $error("conversion never ended");
    chk_upper_nostart: assert property (interface_select && run[2] == 3'h7
        && $past(busy_n) |-> busy_n) else $error("upper byte read started a conversion");
    chk_idle_float: assert property (run[0] == 3'h7 |-> data_oe == 8'h00)
        else $error("pins driven while deselected");
    chk_read_drive: assert property (run[1] == 3'h7 |-> data_oe == 8'hff)
        else $error("pins not driven during a read");
    chk_upper_zero: assert property (run[1] == 3'h7 && run[2] == 3'h7
        |-> data_out[7:4] == 4'h0) else $error("upper nibble not zero");
    chk_ser_pins: assert property (run[4] == 3'h7
        |-> data_out[4:0] == 5'h00 && data_oe[4:0] == 5'h1f) else $error("serial low pins");
    chk_ser_float: assert property (run[4] == 3'h7 && run[5] == 3'h7
        |-> data_oe[6:5] == 2'b00) else $error("serial clock or strobe not floated");
    chk_old_result: assert property (run[1] == 3'h7 && run[3] == 3'h7 && !busy_n
        && !$past(busy_n) |-> $stable(data_out)) else $error("latch changed while busy");
    chk_back_track: assert property (run[0] == 3'h7 && busy_n && $past(busy_n, 4)
        |-> ##[0:4] !hold_active) else $error("hold kept while idle");
endmodule // sahi_chk
bind sahi_core sahi_chk i_chk (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n),
    .upper_byte_select(upper_byte_select), .interface_select(interface_select),
    .busy_n(busy_n), .hold_active(hold_active), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// ---- dv/sahi_afe.sv ----
// analog front end and external conversion clock facing the core
`timescale 1ns/1ps
`default_nettype none
module sahi_afe
    import sahi_pkg::*;
#(
    parameter int HALF_NS = 500 // half period of a 1 mhz clock
) (
    input wire logic hold_active,
    input wire logic [sahi_pkg::RES_BITS-1:0] dac_code,
    input wire logic [sahi_pkg::RES_BITS-1:0] vin,
    output logic conv_clk,
    output logic comparator_high
);
    import sahi_pkg::*;
    logic [11:0] held; // input seen by the comparator
    // free running external clock, kept inside the allowed range
    initial begin
        conv_clk = 1'b0;
        forever #(HALF_NS) conv_clk = ~conv_clk;
    end
    // track the input while not in hold, freeze it in hold
    always_latch begin
        if (!hold_active) begin
            held <= vin;
        end
    end
    // ideal comparator: keep the trial bit while the input is not below it
    assign comparator_high = (held >= dac_code);
endmodule // sahi_afe
`default_nettype wire

// ---- dv/sar_adc_host_interface_test.sv ----
// self-checking bench of the converter core against a reference model
`timescale 1ns/1ps
`default_nettype none
module sar_adc_host_interface_test;
    import sahi_pkg::*;
    logic clk_sys, rstn, cs_n, rd_n, upper_byte_select, interface_select;
    logic signed_range_select, ext_clock_select, conv_clk_in, comparator_high;
    logic busy_n, hold_active;
    logic [11:0] dac_code, vin, last;
    logic [7:0] data_out, data_oe;
    logic [31:0] seed = 32'h0000_a245; // xorshift state
    int error_cnt = 0;
    int tests_run = 0;
    int exp_q[$]; // expected results in start order
    sahi_core i_dut (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n),
        .upper_byte_select(upper_byte_select), .interface_select(interface_select),
        .signed_range_select(signed_range_select), .ext_clock_select(ext_clock_select),
        .conv_clk_in(conv_clk_in), .comparator_high(comparator_high), .busy_n(busy_n),
        .hold_active(hold_active), .dac_code(dac_code), .data_out(data_out),
        .data_oe(data_oe));
    sahi_afe i_afe (.hold_active(hold_active), .dac_code(dac_code), .vin(vin),
        .conv_clk(conv_clk_in), .comparator_high(comparator_high));
    // ==========================================================
    // helpers
    task automatic results();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", what, e, s);
            error_cnt++;
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // drive the three strobes just after a rising edge
    task automatic pins(input logic c, input logic r, input logic u);
        @(posedge clk_sys);
        cs_n <= c;
        rd_n <= r;
        upper_byte_select <= u;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // start a conversion well clear of an edge of the conversion clock pin
    task automatic start_pins();
        logic c0;
        int i;
        c0 = conv_clk_in;
        for (i = 0; i < 120 && conv_clk_in === c0; i++) @(negedge clk_sys);
        if (conv_clk_in === c0) begin
            error_cnt++;
            results();
        end
        settle(10);
        pins(1'b0, 1'b0, 1'b0);
    endtask
    // bounded wait for busy to reach a level
    task automatic wait_busy(input logic v);
        int i;
        for (i = 0; i < 4000 && busy_n !== v; i++) @(negedge clk_sys);
        chk("busy_n", {15'h0000, v}, {15'h0000, busy_n});
        if (busy_n !== v) results();
    endtask
    // ==========================================================
    // parallel conversion read low byte first, then the upper byte
    task automatic par_conv();
        seed = xs(seed);
        @(posedge clk_sys);
        vin <= seed[11:0];
        exp_q.push_back(int'(seed[11:0] ^ (signed_range_select ? MSB_INVERT : 12'h000)));
        start_pins();
        wait_busy(1'b0);
        settle(6);
        chk("old low byte", {8'h00, last[7:0]}, {8'h00, data_out});
        @(posedge clk_sys);
        vin <= ~vin;
        pins(1'b0, 1'b1, 1'b0);
        pins(1'b0, 1'b0, 1'b0);
        wait_busy(1'b1);
        settle(4);
        last = 12'(exp_q.pop_front());
        chk("new low byte", {8'h00, last[7:0]}, {8'h00, data_out});
        pins(1'b1, 1'b1, 1'b0);
        pins(1'b0, 1'b0, 1'b1);
        settle(8);
        chk("upper byte", {12'h000, last[11:8]}, {8'h00, data_out});
        chk("no upper start", 16'h0001, {15'h0000, busy_n});
        pins(1'b1, 1'b1, 1'b0);
        settle(8);
    endtask
    // serial conversion collected at rising serial clock edges
    task automatic ser_conv();
        logic [12:0] sh;
        logic p6;
        int n;
        int i;
        seed = xs(seed);
        @(posedge clk_sys);
        vin <= seed[11:0];
        interface_select <= 1'b0;
        signed_range_select <= 1'b0;
        exp_q.push_back(int'(seed[11:0]));
        start_pins();
        wait_busy(1'b0);
        sh = 13'h0000;
        p6 = 1'b0;
        n = 0;
        for (i = 0; i < 4000 && n < 13; i++) begin
            @(negedge clk_sys);
            if (data_oe[7] === 1'b1 && data_out[6] === 1'b1 && p6 === 1'b0) begin
                if (n == 0) chk("frame strobe", 16'h0001, {15'h0000, data_out[5]});
                sh = {sh[11:0], data_out[7]};
                n++;
            end
            p6 = data_out[6];
        end
        chk("bit count", 16'h000d, 16'(n));
        if (n < 13) results();
        chk("busy at last bit", 16'h0000, {15'h0000, busy_n});
        last = 12'(exp_q.pop_front());
        chk("serial word", {4'h0, last}, {3'b000, sh});
        chk("low pins", 16'h03e0, {6'h00, data_oe[4:0], data_out[4:0]});
        pins(1'b0, 1'b1, 1'b0);
        settle(8);
        chk("rd high float", 16'h0004, {13'h0000, data_oe[7:5]});
        wait_busy(1'b1);
        // upper byte select high keeps the serial clock running while idle
        pins(1'b0, 1'b0, 1'b1);
        p6 = 1'b0;
        n = 0;
        for (i = 0; i < 240; i++) begin
            @(negedge clk_sys);
            if (data_out[6] === 1'b1 && p6 === 1'b0) n++;
            p6 = data_out[6];
        end
        chk("free serial clock", 16'h0001, {15'h0000, n >= 2});
        pins(1'b1, 1'b1, 1'b0);
        settle(8);
        chk("deselect float", 16'h0000, {8'h00, data_oe});
        @(posedge clk_sys);
        interface_select <= 1'b1;
    endtask
    // ==========================================================
    // clock and main sequence
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        rstn = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        upper_byte_select = 1'b0;
        interface_select = 1'b1;
        signed_range_select = 1'b0;
        ext_clock_select = 1'b0;
        vin = 12'h000;
        last = RESULT_RESET;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        settle(2);
        chk("reset pins", 16'h0200, {6'h00, busy_n, hold_active, data_oe});
        // both ranges with internal and external clock
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            signed_range_select <= m[0];
            ext_clock_select <= m[1];
            par_conv();
        end
        ser_conv();
        par_conv();
        results();
    end
endmodule // sar_adc_host_interface_test
`default_nettype wire
